//--- logic/ssf_pkg.sv
package ssf_pkg;

    // register offsets on the register access port
    localparam logic [7:0] ADDR_FAMILY    = 8'h00;
    localparam logic [7:0] ADDR_REV_START = 8'h01;
    localparam logic [7:0] ADDR_GCTRL     = 8'h02;

    // field positions
    localparam int START_BIT   = 0;
    localparam int RSVD3_BIT   = 3;
    localparam int STFL_BIT    = 4;
    localparam int DYNFL_BIT   = 5;
    localparam int RSVD6_BIT   = 6;
    localparam int BACKOFF_BIT = 7;

    // values after reset, and the revision nibble an eeprom image must carry
    localparam logic       START_RESET   = 1'b0;
    localparam logic       BACKOFF_RESET = 1'b0;
    localparam logic [3:0] REV_HI_RESET  = 4'h4;
    localparam logic [2:0] REV_ID_RESET  = 3'h0;
    localparam logic       RSVD3_VALUE   = 1'b1;
    localparam logic       RSVD6_VALUE   = 1'b0;
    localparam logic [3:0] EE_REV_HI_OK  = 4'h0;

    // family code; this value is arbitrary
    localparam logic [7:0] FAMILY_ID_DEFAULT = 8'h3c;

    // eeprom image walk
    localparam logic [7:0] EE_FIRST_BYTE = 8'h00;
    localparam logic [1:0] EE_LAST_IDX   = 2'h2;
    localparam int         EE_WAIT_CYC   = 256;

    // strap pair encodings {hi, lo}
    localparam logic [1:0] STRAP_AUTO    = 2'b00;
    localparam logic [1:0] STRAP_FACTORY = 2'b11;

    localparam int NUM_PORTS = 4;

    typedef enum logic [1:0] {
        SSF_ST_STRAP = 2'b00,
        SSF_ST_READ  = 2'b01,
        SSF_ST_CHECK = 2'b10,
        SSF_ST_RUN   = 2'b11
    } ssf_boot_e;

endpackage

//--- logic/ssf_flush_match.sv
`timescale 1ns/1ps
module ssf_flush_match #(
    parameter int NPORT = 4
) (
    input  wire logic [NPORT-1:0] st_fwd_i,     // static entry forwarding ports
    input  wire logic             st_unicast_i, // static entry address is unicast
    input  wire logic [NPORT-1:0] dyn_port_i,   // dynamic entry port, one-hot
    input  wire logic [NPORT-1:0] learn_dis_i,  // per-port learning disabled
    output logic                  st_hit_o,     // static entry qualifies
    output logic                  dyn_hit_o     // dynamic entry qualifies
);

    logic single_port;

    always_comb begin
        // exactly one forwarding port named
        single_port = (st_fwd_i != '0) && ((st_fwd_i & (st_fwd_i - NPORT'(1))) == '0);
        st_hit_o    = single_port && st_unicast_i && (|(st_fwd_i & learn_dis_i));
        dyn_hit_o   = |(dyn_port_i & learn_dis_i);
    end

endmodule

//--- logic/ssf_global_ctrl.sv
`timescale 1ns/1ps
module ssf_global_ctrl
    import ssf_pkg::*;
#(
    parameter logic [7:0] FAMILY_ID = ssf_pkg::FAMILY_ID_DEFAULT, // arbitrary value
    parameter int         NPORT     = ssf_pkg::NUM_PORTS,
    parameter int         EE_WAIT   = ssf_pkg::EE_WAIT_CYC
) (
    input  wire logic             ref_clk_i,        // core clock, 40 MHz
    input  wire logic             rstn_i,           // async reset, active low
    input  wire logic             strap_select_hi_i, // strap pin, high
    input  wire logic             strap_select_lo_i, // strap pin, low
    input  wire logic             reg_wr_i,         // register write strobe
    input  wire logic             reg_rd_i,         // register read strobe
    input  wire logic [7:0]       reg_addr_i,       // register offset
    input  wire logic [7:0]       reg_wdata_i,      // write data
    output logic      [7:0]       reg_rdata_o,      // read data
    output logic                  reg_rvalid_o,     // read data valid
    output logic                  ee_rd_o,          // eeprom byte request
    output logic      [7:0]       ee_addr_o,        // eeprom byte address
    input  wire logic             ee_ack_i,         // eeprom byte returned
    input  wire logic [7:0]       ee_data_i,        // eeprom byte
    output logic                  ee_ok_o,          // eeprom image accepted
    output logic                  boot_done_o,      // power-up sequence over
    output logic                  switch_en_o,      // switching enabled
    output logic                  backoff_alt_o,    // alternate back-off
    output logic                  dyn_flush_o,      // dynamic flush pending
    input  wire logic             dyn_done_i,       // dynamic flush finished
    output logic                  st_flush_o,       // static flush pending
    input  wire logic             st_done_i,        // static flush finished
    input  wire logic [NPORT-1:0] learn_dis_i,      // per-port learning disabled
    input  wire logic [NPORT-1:0] st_fwd_i,         // static entry ports
    input  wire logic             st_unicast_i,     // static entry unicast
    input  wire logic [NPORT-1:0] dyn_port_i,       // dynamic entry port
    output logic                  st_hit_o,         // static entry to flush
    output logic                  dyn_hit_o         // dynamic entry to flush
);

    import ssf_pkg::*;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);

    ////////////////////////////////////////////////////////////////////////////////
    // power-up sequence state

    localparam logic [15:0] WAIT_LAST = 16'(EE_WAIT - 1);

    ssf_boot_e   state, next_state;
    logic [1:0]  strap, next_strap;
    logic [1:0]  idx, next_idx;
    logic [15:0] wait_cnt, next_wait_cnt;
    logic        ee_seen, next_ee_seen;
    logic [7:0]  img0, next_img0;
    logic [7:0]  img1, next_img1;
    logic [7:0]  img2, next_img2;
    logic        next_ee_rd;
    logic [7:0]  next_ee_addr;
    logic        next_ee_ok;
    logic        next_boot_done;
    logic        img_ok;

    always_comb begin
        next_state     = state;
        next_strap     = strap;
        next_idx       = idx;
        next_wait_cnt  = wait_cnt;
        next_ee_seen   = ee_seen;
        next_img0      = img0;
        next_img1      = img1;
        next_img2      = img2;
        next_ee_rd     = ee_rd_o;
        next_ee_addr   = ee_addr_o;
        next_ee_ok     = ee_ok_o;
        next_boot_done = boot_done_o;
        img_ok = ee_seen && (img0 == FAMILY_ID) && (img1[7:4] == EE_REV_HI_OK);
        case (state)
            SSF_ST_STRAP: begin
                // straps caught one edge after reset release
                next_strap    = {strap_select_hi_i, strap_select_lo_i};
                next_idx      = '0;
                next_wait_cnt = '0;
                next_ee_rd    = 1'b1;
                next_ee_addr  = EE_FIRST_BYTE;
                next_state    = SSF_ST_READ;
            end
            SSF_ST_READ: begin
                if (ee_ack_i) begin
                    next_ee_seen  = 1'b1;
                    next_wait_cnt = '0;
                    case (idx)
                        2'h0:    next_img0 = ee_data_i;
                        2'h1:    next_img1 = ee_data_i;
                        default: next_img2 = ee_data_i;
                    endcase
                    if (idx == EE_LAST_IDX) begin
                        next_ee_rd = 1'b0;
                        next_state = SSF_ST_CHECK;
                    end else begin
                        next_idx     = idx + 2'h1;
                        next_ee_addr = ee_addr_o + 8'h01;
                    end
                end else if (wait_cnt == WAIT_LAST) begin
                    // no answer: treat the eeprom as absent
                    next_ee_rd   = 1'b0;
                    next_ee_seen = 1'b0;
                    next_state   = SSF_ST_CHECK;
                end else begin
                    next_wait_cnt = wait_cnt + 16'h0001;
                end
            end
            SSF_ST_CHECK: begin
                next_ee_ok     = img_ok;
                next_boot_done = 1'b1;
                next_state     = SSF_ST_RUN;
            end
            SSF_ST_RUN: begin
                next_state = SSF_ST_RUN;
            end
            default: begin
                next_state = SSF_ST_STRAP;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state       <= SSF_ST_STRAP;
            strap       <= STRAP_AUTO;
            idx         <= '0;
            wait_cnt    <= '0;
            ee_seen     <= 1'b0;
            img0        <= '0;
            img1        <= '0;
            img2        <= '0;
            ee_rd_o     <= 1'b0;
            ee_addr_o   <= EE_FIRST_BYTE;
            ee_ok_o     <= 1'b0;
            boot_done_o <= 1'b0;
        end else begin
            state       <= next_state;
            strap       <= next_strap;
            idx         <= next_idx;
            wait_cnt    <= next_wait_cnt;
            ee_seen     <= next_ee_seen;
            img0        <= next_img0;
            img1        <= next_img1;
            img2        <= next_img2;
            ee_rd_o     <= next_ee_rd;
            ee_addr_o   <= next_ee_addr;
            ee_ok_o     <= next_ee_ok;
            boot_done_o <= next_boot_done;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // control registers

    logic       start, next_start;
    logic       next_backoff;
    logic       next_dyn, next_st;
    logic       next_switch_en;
    logic       wr_rev, wr_gctrl;
    logic       dyn_set, st_set;
    logic [7:0] next_rdata;
    logic       st_hit_c, dyn_hit_c;

    always_comb begin
        wr_rev   = reg_wr_i && (reg_addr_i == ADDR_REV_START);
        wr_gctrl = reg_wr_i && (reg_addr_i == ADDR_GCTRL);
        dyn_set  = wr_gctrl && reg_wdata_i[DYNFL_BIT];
        st_set   = wr_gctrl && reg_wdata_i[STFL_BIT];
        next_start   = wr_rev ? reg_wdata_i[START_BIT] : start;
        next_backoff = wr_gctrl ? reg_wdata_i[BACKOFF_BIT] : backoff_alt_o;
        // a new trigger in the done cycle keeps the request standing
        next_dyn = (dyn_flush_o && !dyn_done_i) || dyn_set;
        next_st  = (st_flush_o && !st_done_i) || st_set;
        if (state == SSF_ST_CHECK) begin
            next_start = (strap == STRAP_AUTO);
            if (img_ok) begin
                next_backoff = img2[BACKOFF_BIT];
            end
        end
        next_switch_en = next_start && (next_state == SSF_ST_RUN);
        case (reg_addr_i)
            ADDR_FAMILY:    next_rdata = FAMILY_ID;
            ADDR_REV_START: next_rdata = {REV_HI_RESET, REV_ID_RESET, start};
            ADDR_GCTRL:     next_rdata = {backoff_alt_o, RSVD6_VALUE, dyn_flush_o,
                                          st_flush_o, RSVD3_VALUE, 3'h0};
            default:        next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            start         <= START_RESET;
            switch_en_o   <= START_RESET;
            backoff_alt_o <= BACKOFF_RESET;
            dyn_flush_o   <= 1'b0;
            st_flush_o    <= 1'b0;
            reg_rdata_o   <= 8'h00;
            reg_rvalid_o  <= 1'b0;
        end else begin
            start         <= next_start;
            switch_en_o   <= next_switch_en;
            backoff_alt_o <= next_backoff;
            dyn_flush_o   <= next_dyn;
            st_flush_o    <= next_st;
            reg_rdata_o   <= reg_rd_i ? next_rdata : reg_rdata_o;
            reg_rvalid_o  <= reg_rd_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // flush qualification of the entry under the table walker

    ssf_flush_match #(
        .NPORT(NPORT)
    ) u_match (
        .st_fwd_i    (st_fwd_i),
        .st_unicast_i(st_unicast_i),
        .dyn_port_i  (dyn_port_i),
        .learn_dis_i (learn_dis_i),
        .st_hit_o    (st_hit_c),
        .dyn_hit_o   (dyn_hit_c)
    );

    logic next_st_hit, next_dyn_hit;

    always_comb begin
        next_st_hit  = st_flush_o && st_hit_c;
        next_dyn_hit = dyn_flush_o && dyn_hit_c;
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_hit_o  <= 1'b0;
            dyn_hit_o <= 1'b0;
        end else begin
            st_hit_o  <= next_st_hit;
            dyn_hit_o <= next_dyn_hit;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    logic       in_check, img_hi_ok, img2_bo, wbit_bo;

    always_comb begin
        in_check  = (state == SSF_ST_CHECK);
        img_hi_ok = (img1[7:4] == EE_REV_HI_OK);
        img2_bo   = img2[BACKOFF_BIT];
        wbit_bo   = reg_wdata_i[BACKOFF_BIT];
    end

    sequence s_stop_write;
        wr_rev && !reg_wdata_i[START_BIT] && !in_check;
    endsequence

    sequence s_dyn_end;
        dyn_flush_o && dyn_done_i && !dyn_set;
    endsequence

    sequence s_st_end;
        st_flush_o && st_done_i && !st_set;
    endsequence

    AST_STOP_HALTS: assert property (s_stop_write |=> !switch_en_o)
        else $error("start bit cleared but switching still enabled");

    AST_AUTO_START: assert property (in_check && strap == STRAP_AUTO |=> switch_en_o)
        else $error("auto strap did not start switching after eeprom attempt");

    AST_STRAP_WAIT: assert property (in_check && strap != STRAP_AUTO |=> !switch_en_o)
        else $error("non-auto strap started without software");

    AST_ABSENT_KEEP: assert property (in_check && !ee_seen && !wr_gctrl
                                      |=> !ee_ok_o && backoff_alt_o == $past(backoff_alt_o))
        else $error("absent eeprom changed defaults");

    AST_IMAGE_CHECK: assert property (in_check |=> ee_ok_o == ($past(ee_seen)
                                      && $past(img0) == FAMILY_ID && $past(img_hi_ok)))
        else $error("eeprom image check wrong");

    AST_IMAGE_LOAD: assert property (in_check && img_ok
                                     |=> backoff_alt_o == $past(img2_bo) ##1 boot_done_o)
        else $error("valid eeprom image not loaded");

    AST_BACKOFF_WR: assert property (wr_gctrl && !in_check |=> backoff_alt_o == $past(wbit_bo))
        else $error("back-off select did not follow write");

    AST_DYN_TRIG: assert property (dyn_set |=> dyn_flush_o)
        else $error("dynamic flush trigger lost");

    AST_DYN_CLEAR: assert property (s_dyn_end |=> !dyn_flush_o)
        else $error("dynamic flush did not self-clear");

    AST_ST_CLEAR: assert property (s_st_end |=> !st_flush_o)
        else $error("static flush did not self-clear");

    AST_ST_MATCH: assert property (st_hit_o |-> $past(st_flush_o)
                                   && $past(st_unicast_i) && $onehot($past(st_fwd_i))
                                   && ($past(st_fwd_i) & $past(learn_dis_i)) != '0)
        else $error("static hit without qualifying entry");

    AST_DYN_MATCH: assert property (dyn_hit_o |-> $past(dyn_flush_o)
                                    && ($past(dyn_port_i) & $past(learn_dis_i)) != '0)
        else $error("dynamic hit on learning port");

endmodule

//--- sim/ssf_ee_model.sv
`timescale 1ns/1ps
// configuration memory on the far side: answers byte requests after a set wait
module ssf_ee_model (
    input  wire logic       clk_i,     // core clock
    input  wire logic       present_i, // memory fitted
    input  wire logic [3:0] dly_i,     // wait cycles before each answer
    input  wire logic [7:0] img0_i,    // byte 0 image
    input  wire logic [7:0] img1_i,    // byte 1 image
    input  wire logic [7:0] img2_i,    // byte 2 image
    input  wire logic       rd_i,      // byte request
    input  wire logic [7:0] addr_i,    // byte address
    output logic            ack_o,     // byte returned
    output logic      [7:0] data_o     // byte value
);
    logic [3:0] cnt;
    initial begin
        ack_o = 1'b0;
        data_o = 8'h00;
        cnt = 4'h0;
    end
    always @(posedge clk_i) begin
        ack_o <= 1'b0;
        // released bus keeps toggling so a stale byte is never mistaken for data
        data_o <= ~data_o;
        if (present_i && rd_i && !ack_o) begin
            if (cnt == dly_i) begin
                ack_o <= 1'b1;
                cnt <= 4'h0;
                data_o <= (addr_i == 8'h00) ? img0_i :
                          (addr_i == 8'h01) ? img1_i : img2_i;
            end else begin
                cnt <= cnt + 4'h1;
            end
        end else if (!rd_i) begin
            cnt <= 4'h0;
        end
    end
endmodule

//--- sim/tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_count++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_top;
    import ssf_pkg::*;
    logic       clk = 1'b0, rstn = 1'b0, s_hi = 1'b0, s_lo = 1'b0;
    logic       wr = 1'b0, rd = 1'b0, ee_rd, ee_ack, ee_ok, done, sw_en, boff;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, ee_addr, ee_data;
    logic       rvalid, dyn_fl, st_fl, dyn_done = 1'b0, st_done = 1'b0, uni = 1'b0;
    logic       st_hit, dyn_hit, pres = 1'b0;
    logic [3:0] learn = 4'h0, fwd = 4'h0, dport = 4'h0, dly = 4'h0;
    logic [7:0] img0 = 8'h00, img1 = 8'h00, img2 = 8'h00;
    int         err_count = 0, total_checks = 0;

    initial begin
        forever #12.5 clk = ~clk;
    end

    ssf_global_ctrl #(.EE_WAIT(8)) dut (
        .ref_clk_i(clk), .rstn_i(rstn), .strap_select_hi_i(s_hi), .strap_select_lo_i(s_lo),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .ee_rd_o(ee_rd), .ee_addr_o(ee_addr),
        .ee_ack_i(ee_ack), .ee_data_i(ee_data), .ee_ok_o(ee_ok), .boot_done_o(done),
        .switch_en_o(sw_en), .backoff_alt_o(boff), .dyn_flush_o(dyn_fl),
        .dyn_done_i(dyn_done), .st_flush_o(st_fl), .st_done_i(st_done),
        .learn_dis_i(learn), .st_fwd_i(fwd), .st_unicast_i(uni), .dyn_port_i(dport),
        .st_hit_o(st_hit), .dyn_hit_o(dyn_hit));

    ssf_ee_model ee (
        .clk_i(clk), .present_i(pres), .dly_i(dly), .img0_i(img0), .img1_i(img1),
        .img2_i(img2), .rd_i(ee_rd), .addr_i(ee_addr), .ack_o(ee_ack), .data_o(ee_data));

    task automatic stop_test();
        $display("checks=%0d mismatches=%0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(negedge clk);
        wr <= 1'b0;
        @(negedge clk);
    endtask

    task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
        int n;
        @(negedge clk);
        rd <= 1'b1;
        addr <= a;
        @(negedge clk);
        rd <= 1'b0;
        for (n = 0; n < 4 && rvalid !== 1'b1; n++) begin
            @(negedge clk);
        end
        if (n == 4) begin
            err_count++;
            stop_test();
        end
        `CHK(rdata, exp)
    endtask

    // strap pair {hi,lo}, memory fitted, image bytes, answer delay
    task automatic boot(input logic [1:0] st, input logic p, input logic [7:0] b0,
                        input logic [7:0] b1, input logic [7:0] b2, input logic [3:0] dl);
        int n;
        @(negedge clk);
        rstn <= 1'b0;
        {s_hi, s_lo} <= st;
        pres <= p;
        {img0, img1, img2} <= {b0, b1, b2};
        dly <= dl;
        repeat (16) @(negedge clk);
        rstn <= 1'b1;
        for (n = 0; n < 100 && done !== 1'b1; n++) begin
            @(negedge clk);
        end
        if (n == 100) begin
            err_count++;
            stop_test();
        end
        `CHK(ee_rd, 1'b0)
    endtask

    // present one table entry and look at both hit flags a cycle later
    task automatic entry(input logic [3:0] f, input logic u, input logic [3:0] dp,
                         input logic es, input logic ed);
        @(negedge clk);
        fwd <= f;
        uni <= u;
        dport <= dp;
        @(negedge clk);
        `CHK(st_hit, es)
        `CHK(dyn_hit, ed)
    endtask

    initial begin
        // straps 11 never used: reserved for factory
        boot(2'b00, 1'b0, 8'h00, 8'h00, 8'h00, 4'h0);
        `CHK(sw_en, 1'b1)
        `CHK(ee_ok, 1'b0)
        reg_rd(ADDR_GCTRL, 8'h08);
        reg_rd(ADDR_FAMILY, FAMILY_ID_DEFAULT);
        reg_rd(8'h7f, 8'h00);
        $display("test auto start done");

        boot(2'b10, 1'b0, 8'h00, 8'h00, 8'h00, 4'h0);
        `CHK(sw_en, 1'b0)
        reg_rd(ADDR_REV_START, 8'h40);
        reg_wr(ADDR_REV_START, 8'h01);
        `CHK(sw_en, 1'b1)
        reg_rd(ADDR_REV_START, 8'h41);
        reg_wr(ADDR_REV_START, 8'h00);
        `CHK(sw_en, 1'b0)
        $display("test soft start done");

        boot(2'b01, 1'b1, FAMILY_ID_DEFAULT, 8'h01, 8'h88, 4'h3);
        `CHK(ee_ok, 1'b1)
        `CHK(boff, 1'b1)
        `CHK(sw_en, 1'b0)
        reg_rd(ADDR_GCTRL, 8'h88);
        boot(2'b00, 1'b1, FAMILY_ID_DEFAULT, 8'h40, 8'h88, 4'h0);
        `CHK(ee_ok, 1'b0)
        `CHK(boff, 1'b0)
        boot(2'b00, 1'b1, ~FAMILY_ID_DEFAULT, 8'h00, 8'h88, 4'h0);
        `CHK(ee_ok, 1'b0)
        `CHK(sw_en, 1'b1)
        $display("test image check done");

        // software turns learning off on one port before flushing
        learn <= 4'b0010;
        entry(4'b0010, 1'b1, 4'b0010, 1'b0, 1'b0);
        reg_wr(ADDR_GCTRL, 8'h28);
        `CHK(dyn_fl, 1'b1)
        reg_rd(ADDR_GCTRL, 8'h28);
        entry(4'b0000, 1'b0, 4'b0010, 1'b0, 1'b1);
        entry(4'b0000, 1'b0, 4'b0100, 1'b0, 1'b0);
        dyn_done <= 1'b1;
        @(negedge clk);
        dyn_done <= 1'b0;
        @(negedge clk);
        `CHK(dyn_fl, 1'b0)
        reg_rd(ADDR_GCTRL, 8'h08);
        reg_wr(ADDR_GCTRL, 8'h18);
        `CHK(st_fl, 1'b1)
        entry(4'b0010, 1'b1, 4'b0000, 1'b1, 1'b0);
        entry(4'b0110, 1'b1, 4'b0000, 1'b0, 1'b0);
        entry(4'b0010, 1'b0, 4'b0000, 1'b0, 1'b0);
        entry(4'b0100, 1'b1, 4'b0000, 1'b0, 1'b0);
        st_done <= 1'b1;
        @(negedge clk);
        st_done <= 1'b0;
        @(negedge clk);
        `CHK(st_fl, 1'b0)
        reg_rd(ADDR_GCTRL, 8'h08);
        $display("test flush done");

        reg_wr(ADDR_GCTRL, 8'h88);
        `CHK(boff, 1'b1)
        reg_rd(ADDR_GCTRL, 8'h88);
        reg_wr(ADDR_GCTRL, 8'h08);
        `CHK(boff, 1'b0)
        $display("test back-off done");
        stop_test();
    end

    initial begin
        #2000000;
        err_count++;
        stop_test();
    end
endmodule
